// ==== hdl/prsc_consts.svh ====
// Purpose: Offsets, field positions and reset values of the power/reset status control
// Assumes: 32-bit AXI4-Lite register window, byte addresses
// Notes: Included by name by the top module and the bench
//
// How it works
// R1: Battery reset sets status bit 5; write-one clears
// R2: Coinciding new battery reset beats the clear
// R3: Status bit 3 reads 1 while main-power reset inactive
// R4: Status bit 2 follows main power-good input
// R5: Control bit 8 picks legacy pin or serial reset
// R6: Firmware clears bit 8 when serial link used
// R7: Control bit 0 drives power-OK pin, default 1
// R8: Control bit 0 frozen while power-good low
// R9: Control bit 0 high asserts internal main-power reset
// R10: Reserved bits read zero, ignore writes
`ifndef PRSC_CONSTS_SVH
`define PRSC_CONSTS_SVH

// ==========================================================
// Register offsets
`define PRSC_OFF_STATUS 8'h10
`define PRSC_OFF_CONTROL 8'h14
`define PRSC_OFF_INT_STATUS 8'h20
`define PRSC_OFF_INT_MASK 8'h24

// ==========================================================
// Field positions
`define PRSC_ST_VBAT_BIT 5
`define PRSC_ST_HOST_BIT 3
`define PRSC_ST_PGOOD_BIT 2
`define PRSC_CT_SEL_BIT 8
`define PRSC_CT_PVC_BIT 0
`define PRSC_INT_VBAT_BIT 0
`define PRSC_INT_PG_RISE_BIT 1
`define PRSC_INT_PG_FALL_BIT 2
`define PRSC_INT_W 3

// ==========================================================
// Reset values and bus answers
`define PRSC_RST_SEL 1'h1
`define PRSC_RST_PVC 1'h1
`define PRSC_RST_VBAT 1'h0
`define PRSC_RESP_OKAY 2'h0
`define PRSC_RESP_SLVERR 2'h2

`endif

// ==== hdl/prsc_pkg.sv ====
// Purpose: Types for the power/reset status control
// Assumes: Constants come from prsc_consts.svh
// Notes: Write and read channel states are one-hot
package prsc_pkg;

   typedef enum logic [1:0] {
      PRSC_WR_IDLE = 2'b01,
      PRSC_WR_RESP = 2'b10
   } prsc_wr_state_t;

   typedef enum logic [1:0] {
      PRSC_RD_IDLE = 2'b01,
      PRSC_RD_RESP = 2'b10
   } prsc_rd_state_t;

endpackage

// ==== hdl/prsc_top.sv ====
// Purpose: Power and reset status/control registers behind an AXI4-Lite slave
// Assumes: All pin inputs synchronous to clock_i; one write and one read in flight
// Notes: Status and control words plus an interrupt status/mask pair
`timescale 1ns/10ps
`include "prsc_consts.svh"

module prsc_top
   import prsc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   // AXI4-Lite read data
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   // Power and reset pins
   input wire logic battery_reset_i,
   input wire logic main_power_good_i,
   input wire logic legacy_bus_reset_pin_n_i,
   input wire logic serial_platform_reset_n_i,
   output logic power_ok_pin_o,
   output logic main_power_reset_o,
   output logic platform_reset_n_o,
   // Interrupt
   output logic irq_o
);

   // ==========================================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Address decode, shared by both channels
   function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] addr);
      logic [3:0] sel;
      sel = 4'h0;
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`PRSC_OFF_STATUS >> 2)) begin
         sel[0] = 1'b1;
      end
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`PRSC_OFF_CONTROL >> 2)) begin
         sel[1] = 1'b1;
      end
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`PRSC_OFF_INT_STATUS >> 2)) begin
         sel[2] = 1'b1;
      end
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`PRSC_OFF_INT_MASK >> 2)) begin
         sel[3] = 1'b1;
      end
      return sel;
   endfunction

   // ==========================================================
   // Write channel
   prsc_wr_state_t wr_state_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic aw_full_reg;
   logic w_full_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   wire aw_fire = s_axi_awvalid_i && awready_reg;
   wire w_fire = s_axi_wvalid_i && wready_reg;
   wire b_fire = bvalid_reg && s_axi_bready_i;
   // Both halves held: the write takes effect in this single cycle
   wire wr_do = (wr_state_reg == PRSC_WR_IDLE) && aw_full_reg && w_full_reg;
   wire [3:0] wr_sel = reg_sel(awaddr_reg);
   wire wr_hit = |wr_sel;
   wire wr_lane0 = wr_do && wstrb_reg[0];
   wire wr_lane1 = wr_do && wstrb_reg[1];

   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wr_state_reg <= PRSC_WR_IDLE;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `PRSC_RESP_OKAY;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         case (wr_state_reg)
            PRSC_WR_IDLE: begin
               awready_reg <= !aw_full_reg && !aw_fire;
               wready_reg <= !w_full_reg && !w_fire;
               if (aw_fire) begin
                  aw_full_reg <= 1'b1;
                  awaddr_reg <= s_axi_awaddr_i;
               end
               if (w_fire) begin
                  w_full_reg <= 1'b1;
                  wdata_reg <= s_axi_wdata_i;
                  wstrb_reg <= s_axi_wstrb_i;
               end
               if (wr_do) begin
                  bvalid_reg <= 1'b1;
                  bresp_reg <= wr_hit ? `PRSC_RESP_OKAY : `PRSC_RESP_SLVERR;
                  wr_state_reg <= PRSC_WR_RESP;
               end
            end
            PRSC_WR_RESP: begin
               if (b_fire) begin
                  bvalid_reg <= 1'b0;
                  aw_full_reg <= 1'b0;
                  w_full_reg <= 1'b0;
                  awready_reg <= 1'b1;
                  wready_reg <= 1'b1;
                  wr_state_reg <= PRSC_WR_IDLE;
               end
            end
            default: begin
               wr_state_reg <= PRSC_WR_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Power and reset state
   logic vbat_flag_reg;
   logic batt_last_reg;
   logic pgood_flag_reg;
   logic pgood_last_reg;
   logic sel_reg;
   logic pvc_reg;
   logic power_ok_reg;
   logic main_rst_reg;
   logic plat_rst_n_reg;
   logic [`PRSC_INT_W-1:0] int_status_reg;
   logic [`PRSC_INT_W-1:0] int_mask_reg;
   logic irq_reg;
   logic pg_primed_reg;

   wire batt_rise = battery_reset_i && !batt_last_reg;
   // No power-good edge until one real sample is held, else reset fakes one
   wire pg_rise = pg_primed_reg && main_power_good_i && !pgood_last_reg;
   wire pg_fall = pg_primed_reg && !main_power_good_i && pgood_last_reg;
   wire vbat_clr = wr_lane0 && wr_sel[0] && wdata_reg[`PRSC_ST_VBAT_BIT];
   // Set beats clear so a battery reset landing on the clear is kept
   wire vbat_next = batt_rise || (vbat_flag_reg && !vbat_clr); // R1 R2
   // Writes to the power-valid bit only land while power-good is high
   wire pvc_wr = wr_lane0 && wr_sel[1] && main_power_good_i; // R8
   wire sel_wr = wr_lane1 && wr_sel[1];
   wire [`PRSC_INT_W-1:0] int_events = {pg_fall, pg_rise, batt_rise};
   wire [`PRSC_INT_W-1:0] int_clr =
      (wr_lane0 && wr_sel[2]) ? wdata_reg[`PRSC_INT_W-1:0] : '0;
   wire [`PRSC_INT_W-1:0] int_status_next =
      int_events | (int_status_reg & ~int_clr);
   wire plat_src_n = sel_reg ? legacy_bus_reset_pin_n_i : serial_platform_reset_n_i; // R5

   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         vbat_flag_reg <= `PRSC_RST_VBAT;
         batt_last_reg <= 1'b0;
         pgood_flag_reg <= 1'b0;
         pgood_last_reg <= 1'b0;
         sel_reg <= `PRSC_RST_SEL;
         pvc_reg <= `PRSC_RST_PVC;
         power_ok_reg <= `PRSC_RST_PVC;
         main_rst_reg <= `PRSC_RST_PVC;
         plat_rst_n_reg <= 1'b0;
         int_status_reg <= '0;
         int_mask_reg <= '0;
         irq_reg <= 1'b0;
         pg_primed_reg <= 1'b0;
      end else begin
         vbat_flag_reg <= vbat_next; // R1
         batt_last_reg <= battery_reset_i;
         pgood_flag_reg <= main_power_good_i; // R4
         pgood_last_reg <= main_power_good_i;
         if (sel_wr) begin
            sel_reg <= wdata_reg[`PRSC_CT_SEL_BIT];
         end
         if (pvc_wr) begin
            pvc_reg <= wdata_reg[`PRSC_CT_PVC_BIT]; // R8
         end
         power_ok_reg <= pvc_reg; // R7
         main_rst_reg <= pvc_reg; // R9
         plat_rst_n_reg <= plat_src_n;
         int_status_reg <= int_status_next;
         if (wr_lane0 && wr_sel[3]) begin
            int_mask_reg <= wdata_reg[`PRSC_INT_W-1:0];
         end
         irq_reg <= |(int_status_next & int_mask_reg);
         pg_primed_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Read channel
   prsc_rd_state_t rd_state_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire ar_fire = s_axi_arvalid_i && arready_reg;
   wire r_fire = rvalid_reg && s_axi_rready_i;
   wire [3:0] rd_sel = reg_sel(s_axi_araddr_i);
   // Unlisted bits stay zero in every word
   wire [31:0] status_word = {26'h0, vbat_flag_reg, 1'b0, !main_rst_reg,
      pgood_flag_reg, 2'h0}; // R3 R10
   wire [31:0] control_word = {23'h0, sel_reg, 7'h0, pvc_reg}; // R10
   wire [31:0] int_status_word = {{(32-`PRSC_INT_W){1'b0}}, int_status_reg};
   wire [31:0] int_mask_word = {{(32-`PRSC_INT_W){1'b0}}, int_mask_reg};
   wire [31:0] rd_word = ({32{rd_sel[0]}} & status_word) |
      ({32{rd_sel[1]}} & control_word) |
      ({32{rd_sel[2]}} & int_status_word) |
      ({32{rd_sel[3]}} & int_mask_word);

   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rd_state_reg <= PRSC_RD_IDLE;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `PRSC_RESP_OKAY;
      end else begin
         case (rd_state_reg)
            PRSC_RD_IDLE: begin
               arready_reg <= !ar_fire;
               if (ar_fire) begin
                  rvalid_reg <= 1'b1;
                  rdata_reg <= rd_word;
                  rresp_reg <= (|rd_sel) ? `PRSC_RESP_OKAY : `PRSC_RESP_SLVERR;
                  rd_state_reg <= PRSC_RD_RESP;
               end
            end
            PRSC_RD_RESP: begin
               if (r_fire) begin
                  rvalid_reg <= 1'b0;
                  arready_reg <= 1'b1;
                  rd_state_reg <= PRSC_RD_IDLE;
               end
            end
            default: begin
               rd_state_reg <= PRSC_RD_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign power_ok_pin_o = power_ok_reg;
   assign main_power_reset_o = main_rst_reg;
   assign platform_reset_n_o = plat_rst_n_reg;
   assign irq_o = irq_reg;

   // ==========================================================
   // Checks
   AST_VBAT_SET: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R1
      rst_n_reg && batt_rise |=> vbat_flag_reg)
      else $error("battery reset edge did not set the flag");

   AST_VBAT_CLR: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R1
      vbat_clr && !batt_rise |=> !vbat_flag_reg && !status_word[`PRSC_ST_VBAT_BIT])
      else $error("write one did not clear the battery flag");

   AST_VBAT_KEEP: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R2
      vbat_clr && batt_rise |=> vbat_flag_reg && int_status_reg[`PRSC_INT_VBAT_BIT])
      else $error("coinciding battery reset lost to the clear");

   AST_HOST_LIVE: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R3
      ar_fire && rd_sel[0] |=> s_axi_rdata_o[`PRSC_ST_HOST_BIT] == !$past(main_power_reset_o))
      else $error("host reset status disagrees with main-power reset");

   AST_PGOOD: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R4
      rst_n_reg |=> status_word[`PRSC_ST_PGOOD_BIT] == $past(main_power_good_i))
      else $error("power-good status does not follow the input");

   AST_PLAT_SEL: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R5
      rst_n_reg |=> platform_reset_n_o == ($past(sel_reg) ? $past(legacy_bus_reset_pin_n_i) :
      $past(serial_platform_reset_n_i)))
      else $error("platform reset taken from the wrong source");

   AST_POWER_OK_PIN: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R7
      pvc_wr |-> ##2 power_ok_pin_o == $past(wdata_reg[`PRSC_CT_PVC_BIT], 2))
      else $error("power-OK pin does not follow a control write");

   AST_PVC_LOCK: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R8
      !main_power_good_i |=> $stable(pvc_reg))
      else $error("power-valid bit changed while power-good low");

   AST_PVC_WR: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R8
      wr_lane0 && wr_sel[1] && main_power_good_i |=> pvc_reg == $past(wdata_reg[0]))
      else $error("power-valid bit missed a write while power-good high");

   AST_MAIN_RST: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R9
      pvc_reg [*2] |-> main_power_reset_o)
      else $error("main-power reset not asserted with power-valid bit set");

   AST_RSVD: assert property (@(posedge clock_i) disable iff (!rst_n_reg) // R10
      rvalid_reg |-> s_axi_rdata_o[31:9] == 23'h0 && !s_axi_rdata_o[4])
      else $error("reserved read bits not zero");

endmodule

// ==== verification/prsc_host_model.sv ====
// Purpose: Platform-side model driving the power and reset pins
// Assumes: Bench requests change just after a rising edge
// Notes: One request gives a four-cycle battery reset pulse
`timescale 1ns/10ps

module prsc_host_model (
   // Clock
   input wire logic clock_i,
   // Requests from the bench
   input wire logic batt_req_i,
   input wire logic pg_req_i,
   input wire logic legacy_req_i,
   input wire logic serial_req_i,
   // Pins toward the device
   output logic battery_reset_o,
   output logic main_power_good_o,
   output logic legacy_bus_reset_pin_n_o,
   output logic serial_platform_reset_n_o
);
   // ==========================================================
   // Pin drivers
   logic [2:0] batt_cnt_reg = 3'h0;
   logic pg_reg = 1'b1;
   logic lrst_reg = 1'b1;
   logic srst_reg = 1'b1;

   always @(posedge clock_i) begin
      if (batt_req_i) begin
         batt_cnt_reg <= 3'h4;
      end else if (batt_cnt_reg != 3'h0) begin
         batt_cnt_reg <= batt_cnt_reg - 3'h1;
      end
      pg_reg <= pg_req_i;
      lrst_reg <= legacy_req_i;
      srst_reg <= serial_req_i;
   end

   assign battery_reset_o = (batt_cnt_reg != 3'h0);
   assign main_power_good_o = pg_reg;
   assign legacy_bus_reset_pin_n_o = lrst_reg;
   assign serial_platform_reset_n_o = srst_reg;
endmodule

// ==== verification/tb_prsc_top.sv ====
// Purpose: Self-checking bench for the power/reset status control
// Assumes: Answers arrive as the hand-over timing describes
// Notes: Table rows cover plain register accesses, then pin cases
`timescale 1ns/10ps
`include "prsc_consts.svh"

module tb_prsc_top;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [31:0] e;
      logic [1:0] r;
   } prsc_row_t;

   localparam logic [7:0] ST = `PRSC_OFF_STATUS;
   localparam logic [7:0] CT = `PRSC_OFF_CONTROL;
   localparam logic [7:0] IS = `PRSC_OFF_INT_STATUS;
   localparam logic [7:0] IM = `PRSC_OFF_INT_MASK;

   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] ws = 4'h0;
   logic batt_q = 1'b0, pg_q = 1'b1, lrst_q = 1'b1, srst_q = 1'b1;
   logic awr, wrdy, bv, arr, rv, pok, mpr, plt_n, irq, bat, pg, lrst_n, srst_n;
   logic [1:0] brs, rrs, resp;
   logic [31:0] rd, got;
   int failures = 0;
   int checks = 0;
   prsc_row_t rows [7];

   always #2.5 clock_i = ~clock_i;

   prsc_top dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
      .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_bresp_o(brs), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd),
      .s_axi_rresp_o(rrs), .battery_reset_i(bat), .main_power_good_i(pg),
      .legacy_bus_reset_pin_n_i(lrst_n), .serial_platform_reset_n_i(srst_n),
      .power_ok_pin_o(pok), .main_power_reset_o(mpr),
      .platform_reset_n_o(plt_n), .irq_o(irq)
   );

   prsc_host_model host (
      .clock_i(clock_i), .batt_req_i(batt_q), .pg_req_i(pg_q),
      .legacy_req_i(lrst_q), .serial_req_i(srst_q), .battery_reset_o(bat),
      .main_power_good_o(pg), .legacy_bus_reset_pin_n_o(lrst_n),
      .serial_platform_reset_n_o(srst_n)
   );

   // ==========================================================
   // Compare and bus tasks
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aok;
      logic wok;
      aok = 1'b0;
      wok = 1'b0;
      @(posedge clock_i);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      ws <= s;
      bry <= 1'b1;
      do begin
         @(posedge clock_i);
         if (awv && awr === 1'b1) begin
            awv <= 1'b0;
            aok = 1'b1;
         end
         if (wv && wrdy === 1'b1) begin
            wv <= 1'b0;
            wok = 1'b1;
         end
      end while (!(aok && wok));
      do @(posedge clock_i); while (bv !== 1'b1);
      resp = brs;
      bry <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a);
      @(posedge clock_i);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do @(posedge clock_i); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clock_i); while (rv !== 1'b1);
      got = rd;
      resp = rrs;
      rry <= 1'b0;
   endtask

   task automatic batt_event;
      @(posedge clock_i);
      batt_q <= 1'b1;
      @(posedge clock_i);
      batt_q <= 1'b0;
      cyc(8);
   endtask

   task automatic test_done;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      // Zero strobes leave the reset values in place for the first two reads
      rows[0] = '{ST, 32'hFFFF_FFFF, 4'h0, 32'h0000_0004, `PRSC_RESP_OKAY};
      rows[1] = '{CT, 32'h0000_0000, 4'h0, 32'h0000_0101, `PRSC_RESP_OKAY};
      rows[2] = '{IM, 32'h0000_0007, 4'hF, 32'h0000_0007, `PRSC_RESP_OKAY};
      rows[3] = '{CT, 32'hFFFF_FEFE, 4'hF, 32'h0000_0000, `PRSC_RESP_OKAY};
      rows[4] = '{ST, 32'hFFFF_FFFF, 4'hF, 32'h0000_000C, `PRSC_RESP_OKAY};
      rows[5] = '{CT, 32'hFFFF_FFFF, 4'h1, 32'h0000_0001, `PRSC_RESP_OKAY};
      rows[6] = '{8'h30, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, `PRSC_RESP_SLVERR};
      repeat (20) @(posedge clock_i);
      chk_bit(pok, 1'b1);
      chk_bit(mpr, 1'b1);
      chk_bit(plt_n, 1'b0);
      chk_bit(irq, 1'b0);
      rst_n_i <= 1'b1;
      cyc(3);
      for (int i = 0; i < 7; i++) begin
         bus_wr(rows[i].a, rows[i].d, rows[i].s);
         chk_word({30'h0, resp}, {30'h0, rows[i].r});
         bus_rd(rows[i].a);
         chk_word(got, rows[i].e);
         chk_word({30'h0, resp}, {30'h0, rows[i].r});
      end
      chk_bit(pok, 1'b1);
      chk_bit(mpr, 1'b1);
      srst_q <= 1'b0;
      cyc(4);
      chk_bit(plt_n, 1'b0);
      srst_q <= 1'b1;
      lrst_q <= 1'b0;
      cyc(4);
      chk_bit(plt_n, 1'b1);
      bus_wr(CT, 32'h0000_0100, 4'h3);
      cyc(3);
      chk_bit(pok, 1'b0);
      chk_bit(mpr, 1'b0);
      chk_bit(plt_n, 1'b0);
      lrst_q <= 1'b1;
      batt_event;
      chk_bit(irq, 1'b1);
      bus_rd(ST);
      chk_word(got, 32'h0000_002C);
      bus_rd(IS);
      chk_word(got, 32'h0000_0001);
      bus_wr(IS, 32'h0000_0007, 4'hF);
      bus_wr(ST, 32'h0000_0020, 4'h1);
      cyc(3);
      chk_bit(irq, 1'b0);
      bus_rd(ST);
      chk_word(got, 32'h0000_000C);
      bus_wr(IM, 32'h0000_0000, 4'hF);
      batt_event;
      chk_bit(irq, 1'b0);
      // The clear is applied on the same edge that latches the new event
      fork
         bus_wr(ST, 32'h0000_0020, 4'h1);
         batt_event;
      join
      bus_rd(ST);
      chk_word(got, 32'h0000_002C);
      pg_q <= 1'b0;
      cyc(4);
      bus_rd(ST);
      chk_word(got, 32'h0000_0028);
      bus_wr(CT, 32'h0000_0101, 4'h3);
      bus_rd(CT);
      chk_word(got, 32'h0000_0100);
      chk_bit(pok, 1'b0);
      pg_q <= 1'b1;
      cyc(4);
      bus_wr(CT, 32'h0000_0101, 4'h3);
      bus_rd(CT);
      chk_word(got, 32'h0000_0101);
      chk_bit(pok, 1'b1);
      bus_rd(IS);
      chk_word(got, 32'h0000_0007);
      // Mid-run reset with power-good high: defaults return, no false edge
      bus_wr(CT, 32'h0000_0000, 4'h3);
      cyc(2);
      chk_bit(pok, 1'b0);
      rst_n_i <= 1'b0;
      cyc(2);
      chk_bit(pok, 1'b1);
      chk_bit(mpr, 1'b1);
      chk_bit(plt_n, 1'b0);
      rst_n_i <= 1'b1;
      cyc(3);
      bus_rd(CT);
      chk_word(got, 32'h0000_0101);
      bus_rd(ST);
      chk_word(got, 32'h0000_0004);
      bus_rd(IS);
      chk_word(got, 32'h0000_0000);
      test_done;
   end

   initial begin
      #100000;
      failures++;
      test_done;
   end
endmodule
